/* File: pkg/octal_switch_pkg.sv */
// Purpose: shared constants and carriers of the octal switch serial control
// Assumes: eight outputs, command bit high means output off
// Notes:   packed structs carry the per-output fault and drive groups
package octal_switch_pkg;

    localparam int unsigned N_OUT = 8;

    // command value that holds every output off
    localparam logic [N_OUT-1:0] CMD_ALL_OFF = 8'hFF;
    localparam logic [N_OUT-1:0] ALL_CLEAR   = 8'h00;

    // bit counter of one frame, saturates after a full word
    localparam int unsigned      CNT_W     = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
    localparam logic [CNT_W-1:0] CNT_FULL  = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] MSB_INDEX = 4'h7;

    // per-output fault sensing from the analog side
    typedef struct packed {
        logic [N_OUT-1:0] overcurrent;
        logic [N_OUT-1:0] open_load;
    } fault_t;

    // per-output drive toward the power stage
    typedef struct packed {
        logic [N_OUT-1:0] switch_on;
        logic [N_OUT-1:0] current_limit;
    } drive_t;

endpackage

/* File: src/octal_switch_spi_control.sv */
// Purpose: serial command and drain status logic of an eight-output low-side switch
// Assumes: link pins follow SPI timing (clock low at select edges, setup far above 30 ns)
// Notes:   frame logic runs on the serial clock; switch state runs on clk
`timescale 1ns/1ns

module octal_switch_spi_control
    import octal_switch_pkg::*;
#(
    parameter int unsigned OUTPUTS = N_OUT
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic             si,
    input  wire logic             reset_n,
    input  wire logic             short_protect_disable,
    input  wire fault_t           faults,
    output      logic             so,
    output      logic             so_oe,
    output      drive_t           drive
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks: the logic below is written for one fixed word size

    if (OUTPUTS != N_OUT) begin : g_outputs_check
        $error("OUTPUTS must equal the package output count");
    end

    if (CNT_FULL != CNT_W'(N_OUT)) begin : g_count_check
        $error("frame counter must saturate at one full word");
    end

    if (MSB_INDEX != CNT_W'(N_OUT - 1)) begin : g_index_check
        $error("status index must start at the top output");
    end

    if (N_OUT >= (1 << CNT_W)) begin : g_width_check
        $error("frame counter too narrow for the word");
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers into clk

    logic                 cs_n_s_q;
    logic                 cs_n_p_q;
    logic                 cs_n_p_d;
    logic                 rst_pin_s_q;
    logic                 spd_s_q;
    fault_t               flt_s_q;

    // select idles high, so its stages leave reset high and no false edge follows
    sync_2ff #(
        .WIDTH     (1),
        .RESET_VAL (1'b1)
    ) u_sync_cs (
        .clk       (clk),
        .rst       (rst),
        .d         (cs_n),
        .q         (cs_n_s_q)
    );

    // stages leave reset low, so the device reset stays applied until the pin is seen
    sync_2ff #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_sync_rst_pin (
        .clk       (clk),
        .rst       (rst),
        .d         (reset_n),
        .q         (rst_pin_s_q)
    );

    // protect disable and faults are slow levels; a cycle of skew between bits is harmless
    sync_2ff #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_sync_spd (
        .clk       (clk),
        .rst       (rst),
        .d         (short_protect_disable),
        .q         (spd_s_q)
    );

    sync_2ff #(
        .WIDTH     ($bits(fault_t)),
        .RESET_VAL ('0)
    ) u_sync_faults (
        .clk       (clk),
        .rst       (rst),
        .d         (faults),
        .q         (flt_s_q)
    );

    // one more stage of select gives the frame-end edge
    always_comb begin
        cs_n_p_d = cs_n_s_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_n_p_q <= 1'b1;
        end else begin
            cs_n_p_q <= cs_n_p_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame end and device reset, both seen through the synchronisers

    // the shifter is read at frame end without its own synchroniser: the serial
    // clock idles low while select is high, so the word stands still for the
    // two or three clk cycles the select edge takes to come through
    logic                 frame_end;
    logic                 dev_reset;

    assign frame_end = cs_n_s_q & ~cs_n_p_q;
    assign dev_reset = ~rst_pin_s_q;

    ////////////////////////////////////////////////////////////////////////////
    // frame logic on the serial clock

    // the synchronised reset pin clears the shifter without a serial clock edge;
    // it lets go on clk, while the serial clock idles between frames
    logic                 link_clr;
    assign link_clr = rst | dev_reset;

    logic [N_OUT-1:0]     rx_q;
    logic [N_OUT-1:0]     rx_d;
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic                 so_q;
    logic                 so_d;
    logic [N_OUT-1:0]     status_q;

    always_comb begin
        rx_d  = rx_q;
        cnt_d = cnt_q;
        if (!cs_n) begin
            rx_d = {rx_q[N_OUT-2:0], si};
            if (cnt_q != CNT_FULL) begin
                cnt_d = cnt_q + CNT_ONE;
            end
        end
    end

    always_ff @(negedge sclk or posedge link_clr) begin
        if (link_clr) begin
            rx_q <= ALL_CLEAR;
        end else begin
            rx_q <= rx_d;
        end
    end

    // select high ends the frame count without needing a clock edge
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // status occupies the shifter ahead of the received bits, so a full word
    // later the first received bit comes out: daisy chains work unchanged
    always_comb begin
        if (cnt_q < CNT_FULL) begin
            so_d = status_q[3'(MSB_INDEX - cnt_q)];
        end else begin
            so_d = rx_q[N_OUT-1];
        end
    end

    // reset only by the system reset: the reset pin leaves this path alone
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            so_q <= 1'b0;
        end else begin
            so_q <= so_d;
        end
    end

    assign so = so_q;

    ////////////////////////////////////////////////////////////////////////////
    // switch state on clk

    logic [N_OUT-1:0]     cmd_q;
    logic [N_OUT-1:0]     cmd_d;
    logic [N_OUT-1:0]     latched_q;
    logic [N_OUT-1:0]     latched_d;
    logic [N_OUT-1:0]     on_q;
    logic [N_OUT-1:0]     on_d;
    logic [N_OUT-1:0]     limit_q;
    logic [N_OUT-1:0]     limit_d;
    logic [N_OUT-1:0]     status_d;
    logic                 oe_q;
    logic                 oe_d;

    always_comb begin
        cmd_d     = cmd_q;
        latched_d = latched_q;
        // the serial clock idles while select is high, so rx_q is still here
        if (frame_end) begin
            cmd_d     = rx_q;
            latched_d = ALL_CLEAR;
        end
        // a short arriving with the new command still latches: set wins
        latched_d = latched_d | (on_q & flt_s_q.overcurrent
                                 & {N_OUT{~spd_s_q}});
        if (dev_reset) begin
            cmd_d     = CMD_ALL_OFF;
            latched_d = ALL_CLEAR;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_q     <= CMD_ALL_OFF;
            latched_q <= ALL_CLEAR;
        end else begin
            cmd_q     <= cmd_d;
            latched_q <= latched_d;
        end
    end

    // drive follows the new command in the same cycle, so it is never a cycle stale
    always_comb begin
        on_d    = ~cmd_d & ~latched_d;
        limit_d = on_d & flt_s_q.overcurrent & {N_OUT{spd_s_q}};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_q    <= ALL_CLEAR;
            limit_q <= ALL_CLEAR;
        end else begin
            on_q    <= on_d;
            limit_q <= limit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drain status and serial output enable

    // drain high when off and not open, or when on and shorted
    always_comb begin
        status_d = status_q;
        if (cs_n_s_q) begin
            status_d = (on_q & flt_s_q.overcurrent)
                     | (~on_q & ~flt_s_q.open_load);
        end
        oe_d = ~cs_n_s_q;
    end

    // status freezes while select is low, so the link reads a steady word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= CMD_ALL_OFF;
            oe_q     <= 1'b0;
        end else begin
            status_q <= status_d;
            oe_q     <= oe_d;
        end
    end

    assign so_oe               = oe_q;
    assign drive.switch_on     = on_q;
    assign drive.current_limit = limit_q;

endmodule

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for level inputs from another clock domain; only the
// second stage leaves the module, so nothing reads the possibly metastable one
// multi-bit words pass bit by bit: fit only for independent levels

module sync_2ff
    import octal_switch_pkg::*;
#(
    parameter int unsigned      WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0]     meta_q;
    logic [WIDTH-1:0]     meta_d;
    logic [WIDTH-1:0]     sync_q;
    logic [WIDTH-1:0]     sync_d;

    if (WIDTH < 1) begin : g_width_check
        $error("WIDTH must be at least one");
    end

    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;

endmodule

/* File: testbench/octal_switch_sva.sv */
// Purpose: port assertions of the octal switch serial control
// Assumes: link pins seen through clk, sync latency of 2-3 clk
// Notes:   repetition counts leave at least one clk of margin over the sync delay
`timescale 1ns/1ns
module octal_switch_chk
    import octal_switch_pkg::*;
#(
    parameter int unsigned OUTPUTS = N_OUT
) (
    input wire logic   clk,
    input wire logic   rst,
    input wire logic   cs_n,
    input wire logic   reset_n,
    input wire logic   short_protect_disable,
    input wire fault_t faults,
    input wire logic   so_oe,
    input wire drive_t drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    property p_so_float; cs_n[*5] |-> !so_oe; endproperty
    a_so_float: assert property (p_so_float) else $error("so driven while idle");
    property p_so_drive; !cs_n[*5] |-> so_oe; endproperty
    a_so_drive: assert property (p_so_drive) else $error("so not driven in frame");
    property p_rst_so; (!cs_n && !reset_n)[*5] |-> so_oe; endproperty
    a_rst_so: assert property (p_rst_so) else $error("reset pin cut so");
    property p_rst_off; !reset_n[*5] |-> drive.switch_on == ALL_CLEAR; endproperty
    a_rst_off: assert property (p_rst_off) else $error("output on in reset");
    // a switch may only turn on from a command latched at select rise
    property p_on_rise; (drive.switch_on & ~$past(drive.switch_on)) != ALL_CLEAR |-> $past(cs_n, 3);
    endproperty
    a_on_rise: assert property (p_on_rise) else $error("turn on outside frame end");
    property p_lim_on; (drive.current_limit & ~drive.switch_on) == ALL_CLEAR; endproperty
    a_lim_on: assert property (p_lim_on) else $error("limit on an off output");
    property p_limit; short_protect_disable[*6] ##0 (drive.switch_on & faults.overcurrent) !=
        ALL_CLEAR |-> ##[0:5] drive.current_limit != ALL_CLEAR; endproperty
    a_limit: assert property (p_limit) else $error("no current limit");
    property p_latch; not ((!short_protect_disable && (drive.switch_on & faults.overcurrent) !=
        ALL_CLEAR)[*8]); endproperty
    a_latch: assert property (p_latch) else $error("short not latched off");
endmodule
bind octal_switch_spi_control octal_switch_chk #(.OUTPUTS(OUTPUTS)) chk (
    .clk(clk), .rst(rst), .cs_n(cs_n), .reset_n(reset_n), .so_oe(so_oe),
    .short_protect_disable(short_protect_disable), .faults(faults), .drive(drive));

/* File: testbench/spi_master_model.sv */
// Purpose: serial master driving frames of up to 16 bits
// Assumes: 48 ns serial clock, idle low between frames
// Notes:   si is inverted once released so a stale level is never trusted
`timescale 1ns/1ns
module spi_master_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_line
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        cs_n = 1'b0;
        #36;
        for (int i = n - 1; i >= 0; i--) begin
            #12 si = w[i];
            #12 sclk = 1'b1;
            #24 r[i] = so_line;
            sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        si = ~si;
        #96;
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the octal switch serial control
// Assumes: master model owns the link pins, bench owns the rest
// Notes:   expected words follow from command and fault levels
`timescale 1ns/1ns
module tb_top
    import octal_switch_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        reset_n;
    logic        short_protect_disable;
    logic        so;
    logic        so_oe;
    fault_t      faults;
    drive_t      drive;
    logic [15:0] r;
    int          fail_count;
    int          checked;
    wire         sclk;
    wire         cs_n;
    wire         si;
    wire         so_line = so_oe ? so : ~so;
    octal_switch_spi_control #(.OUTPUTS(N_OUT)) uut (
        .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .reset_n(reset_n),
        .short_protect_disable(short_protect_disable), .faults(faults),
        .so(so), .so_oe(so_oe), .drive(drive));
    spi_master_model m (.sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line));
    ////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_frames();
        check("idle oe", 16'(so_oe), 16'h0000);
        m.xfer(8, 16'h005A, r);
        check("status first", r, 16'h00FF);
        wait_clk(6);
        check("on after frame", 16'(drive.switch_on), 16'h00A5);
        faults.open_load = 8'h02;
        wait_clk(4);
        m.xfer(8, 16'h000F, r);
        check("status second", r, 16'h0058);
        m.xfer(16, 16'hAAF0, r);
        check("fifo word", r, 16'h0DAA);
        wait_clk(6);
        check("last byte", 16'(drive.switch_on), 16'h000F);
    endtask
    task automatic t_short();
        short_protect_disable = 1'b1;
        faults.overcurrent = 8'h01;
        wait_clk(10);
        check("limit kept on", {drive.switch_on, drive.current_limit}, 16'h0F01);
        short_protect_disable = 1'b0;
        wait_clk(10);
        check("latched off", 16'(drive.switch_on), 16'h000E);
        faults.overcurrent = 8'h00;
        wait_clk(10);
        check("stays off", 16'(drive.switch_on), 16'h000E);
        m.xfer(8, 16'h00F0, r);
        check("status latched", r, 16'h00F1);
        wait_clk(6);
        check("on again", 16'(drive.switch_on), 16'h000F);
    endtask
    task automatic t_reset_pin();
        reset_n = 1'b0;
        m.xfer(8, 16'h0000, r);
        check("so in pin reset", r, 16'h00F0);
        wait_clk(25);
        check("pin reset off", 16'(drive.switch_on), 16'h0000);
        reset_n = 1'b1;
        wait_clk(10);
        check("off after pin", 16'(drive.switch_on), 16'h0000);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        fail_count = 0;
        checked = 0;
        rst = 1'b1;
        reset_n = 1'b0;
        short_protect_disable = 1'b0;
        faults = '0;
        wait_clk(20);
        rst = 1'b0;
        wait_clk(6);
        reset_n = 1'b1;
        wait_clk(4);
        t_frames();
        t_short();
        t_reset_pin();
        conclude();
    end
    // about 4 us of traffic, so 20 us means a hang
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
endmodule
